// ==== verilog/ivt_map.svh ====
// constants for the interrupt vector and trap map
`ifndef IVT_MAP_SVH
`define IVT_MAP_SVH
`define IVT_N_SRC 50
`define IVT_N_TRAP 9
`define IVT_PRIO_W 4
`define IVT_IDX_W 6
`define IVT_TRAP_W 7
`define IVT_VEC_W 9
`define IVT_TIDX_W 4
// source index of the first member of each group
`define IVT_IDX_CC16 6'h0A
`define IVT_IDX_CC29 6'h17
`define IVT_IDX_T0 6'h1A
`define IVT_IDX_T7 6'h1C
`define IVT_IDX_T2 6'h1E
`define IVT_IDX_ADC 6'h24
`define IVT_IDX_S0T 6'h26
`define IVT_IDX_S0TB 6'h27
`define IVT_IDX_S0R 6'h28
`define IVT_IDX_S0E 6'h29
`define IVT_IDX_SCT 6'h2A
`define IVT_IDX_PWM 6'h2D
`define IVT_IDX_XP0 6'h2E
// trap number of the first member of each group
`define IVT_TRAP_CC6 7'h16
`define IVT_TRAP_CC16 7'h30
`define IVT_TRAP_CC29 7'h44
`define IVT_TRAP_T0 7'h20
`define IVT_TRAP_T7 7'h3D
`define IVT_TRAP_T2 7'h22
`define IVT_TRAP_ADC 7'h28
`define IVT_TRAP_S0T 7'h2A
`define IVT_TRAP_S0TB 7'h47
`define IVT_TRAP_S0R 7'h2B
`define IVT_TRAP_S0E 7'h2C
`define IVT_TRAP_SCT 7'h2D
`define IVT_TRAP_PWM 7'h3F
`define IVT_TRAP_XP0 7'h40
// hardware traps: three dedicated, the rest share one vector
`define IVT_N_TRAP_A 4'h3
`define IVT_TRAP_NMI 7'h02
`define IVT_TRAP_STKOF 7'h04
`define IVT_TRAP_STKUF 7'h06
`define IVT_TRAP_CLASS_B 7'h0A
`define IVT_RANK_NONE 2'h0
`define IVT_RANK_B 2'h1
`define IVT_RANK_A 2'h2
`endif

// ==== verilog/ivt_pkg.sv ====
// types for the interrupt vector and trap map
package ivt_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b01,
    ARB_REQ = 2'b10
  } ivt_arb_state_type;
  typedef enum logic [2:0] {
    TRP_IDLE = 3'b001,
    TRP_REQ = 3'b010,
    TRP_SVC = 3'b100
  } ivt_trp_state_type;
  typedef logic [1:0] ivt_rank_type;
endpackage

// ==== verilog/ivt_flag_if.sv ====
// flag bank carrier between the bank and its controller
interface ivt_flag_if #(parameter int N = 8) ();
  logic [N-1:0] flag;
  logic [N-1:0] pend;
  logic [N-1:0] ack;
  modport bank (output flag, output pend, input ack);
  modport ctrl (input flag, input pend, output ack);
endinterface

// ==== verilog/ivt_flag_bank.sv ====
// sticky request flags gated by enable flags
module ivt_flag_bank #(parameter int N = 8) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [N-1:0] i_event,
  input wire logic [N-1:0] i_enable,
  input wire logic [N-1:0] i_clr,
  ivt_flag_if.bank bus
);
  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  // a new event beats a clear in the same cycle
  assign flag_next = i_event | (flag_reg & ~(i_clr | bus.ack));

  // flag storage
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // request only where flag and enable meet
  assign bus.flag = flag_reg;
  assign bus.pend = flag_reg & i_enable;
endmodule

// ==== verilog/ivt_prio_pick.sv ====
// picks the highest-level pending source above a floor
module ivt_prio_pick #(
  parameter int N = 8,
  parameter int PW = 4,
  parameter int IW = 3
) (
  input wire logic [N-1:0] i_pend,
  input wire logic [N*PW-1:0] i_prio,
  input wire logic [PW-1:0] i_floor,
  output logic o_valid,
  output logic [IW-1:0] o_idx,
  output logic [PW-1:0] o_level
);
  logic [PW-1:0] lvl [N];
  logic [N-1:0] elig;

  // per-source level slice and eligibility
  for (genvar g = 0; g < N; g++) begin : g_src
    assign lvl[g] = i_prio[g*PW +: PW];
    assign elig[g] = i_pend[g] && (lvl[g] > i_floor);
  end

  // strict compare keeps the lowest index on a tie
  always_comb begin
    o_valid = 1'b0;
    o_idx = '0;
    o_level = '0;
    for (int i = 0; i < N; i++) begin
      if (elig[i] && (!o_valid || lvl[i] > o_level)) begin
        o_valid = 1'b1;
        o_idx = IW'(i);
        o_level = lvl[i];
      end
    end
  end
endmodule

// ==== verilog/ivt_top.sv ====
// interrupt source map, level arbitration and hardware trap sequencing
`include "ivt_map.svh"
module ivt_top #(
  parameter int N_SRC = `IVT_N_SRC,
  parameter int N_TRAP = `IVT_N_TRAP,
  parameter int PW = `IVT_PRIO_W
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [N_SRC-1:0] i_src_event,
  input wire logic [N_SRC-1:0] i_src_enable,
  input wire logic [N_SRC-1:0] i_src_clr,
  input wire logic [N_SRC*PW-1:0] i_src_prio,
  input wire logic [PW-1:0] i_cpu_level,
  output logic [N_SRC-1:0] o_src_flag,
  output logic o_int_req,
  output logic [`IVT_TRAP_W-1:0] o_int_trap_num,
  output logic [`IVT_VEC_W-1:0] o_int_vector,
  output logic [PW-1:0] o_int_level,
  input wire logic i_int_ack,
  input wire logic [N_TRAP-1:0] i_trap_event,
  input wire logic [N_TRAP-1:0] i_tfr_clr,
  output logic [N_TRAP-1:0] o_trap_flag,
  output logic o_trap_req,
  output logic [`IVT_TRAP_W-1:0] o_trap_num,
  output logic [`IVT_VEC_W-1:0] o_trap_vector,
  input wire logic i_trap_ack,
  input wire logic i_trap_return,
  output logic o_trap_busy
);
  localparam int IW = `IVT_IDX_W;
  localparam int TW = `IVT_TIDX_W;

  // trap number of a peripheral source index
  function automatic logic [`IVT_TRAP_W-1:0] src_trap(input logic [IW-1:0] idx);
    logic [`IVT_TRAP_W-1:0] t;
    t = `IVT_TRAP_XP0 + 7'(idx - `IVT_IDX_XP0);
    if (idx < `IVT_IDX_CC16) begin
      t = `IVT_TRAP_CC6 + 7'(idx);
    end else if (idx < `IVT_IDX_CC29) begin
      t = `IVT_TRAP_CC16 + 7'(idx - `IVT_IDX_CC16);
    end else if (idx < `IVT_IDX_T0) begin
      t = `IVT_TRAP_CC29 + 7'(idx - `IVT_IDX_CC29);
    end else if (idx < `IVT_IDX_T7) begin
      t = `IVT_TRAP_T0 + 7'(idx - `IVT_IDX_T0);
    end else if (idx < `IVT_IDX_T2) begin
      t = `IVT_TRAP_T7 + 7'(idx - `IVT_IDX_T7);
    end else if (idx < `IVT_IDX_ADC) begin
      t = `IVT_TRAP_T2 + 7'(idx - `IVT_IDX_T2);
    end else if (idx < `IVT_IDX_S0T) begin
      t = `IVT_TRAP_ADC + 7'(idx - `IVT_IDX_ADC);
    end else if (idx == `IVT_IDX_S0T) begin
      t = `IVT_TRAP_S0T;
    end else if (idx == `IVT_IDX_S0TB) begin
      t = `IVT_TRAP_S0TB;
    end else if (idx == `IVT_IDX_S0R) begin
      t = `IVT_TRAP_S0R;
    end else if (idx == `IVT_IDX_S0E) begin
      t = `IVT_TRAP_S0E;
    end else if (idx < `IVT_IDX_PWM) begin
      t = `IVT_TRAP_SCT + 7'(idx - `IVT_IDX_SCT);
    end else if (idx == `IVT_IDX_PWM) begin
      t = `IVT_TRAP_PWM;
    end
    return t;
  endfunction

  // vector location is four times the trap number
  function automatic logic [`IVT_VEC_W-1:0] trap_vec(input logic [`IVT_TRAP_W-1:0] t);
    return {t, 2'b00};
  endfunction

  // trap number of a hardware trap index
  function automatic logic [`IVT_TRAP_W-1:0] hw_trap(input logic [TW-1:0] ti);
    logic [`IVT_TRAP_W-1:0] t;
    t = `IVT_TRAP_CLASS_B;
    if (ti == 4'h0) begin
      t = `IVT_TRAP_NMI;
    end else if (ti == 4'h1) begin
      t = `IVT_TRAP_STKOF;
    end else if (ti == 4'h2) begin
      t = `IVT_TRAP_STKUF;
    end
    return t;
  endfunction

  // priority rank of a hardware trap index
  function automatic ivt_pkg::ivt_rank_type hw_rank(input logic [TW-1:0] ti);
    return (ti < `IVT_N_TRAP_A) ? `IVT_RANK_A : `IVT_RANK_B;
  endfunction

  ivt_flag_if #(.N(N_SRC)) src_if ();
  ivt_flag_if #(.N(N_TRAP)) tfr_if ();

  // peripheral request and enable flags
  ivt_flag_bank #(.N(N_SRC)) u_src_bank (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_event(i_src_event),
    .i_enable(i_src_enable),
    .i_clr(i_src_clr),
    .bus(src_if.bank)
  );

  // trap flag register, never masked
  ivt_flag_bank #(.N(N_TRAP)) u_tfr_bank (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_event(i_trap_event),
    .i_enable({N_TRAP{1'b1}}),
    .i_clr(i_tfr_clr),
    .bus(tfr_if.bank)
  );

  logic pick_valid;
  logic [IW-1:0] pick_idx;
  logic [PW-1:0] pick_level;

  // best pending source above the running level
  ivt_prio_pick #(.N(N_SRC), .PW(PW), .IW(IW)) u_pick (
    .i_pend(src_if.pend),
    .i_prio(i_src_prio),
    .i_floor(i_cpu_level),
    .o_valid(pick_valid),
    .o_idx(pick_idx),
    .o_level(pick_level)
  );

  ivt_pkg::ivt_arb_state_type arb_state_reg;
  ivt_pkg::ivt_arb_state_type arb_state_next;
  ivt_pkg::ivt_trp_state_type trp_state_reg;
  ivt_pkg::ivt_trp_state_type trp_state_next;
  logic [IW-1:0] held_idx_reg;
  logic [PW-1:0] held_level_reg;
  logic [`IVT_TRAP_W-1:0] int_trap_reg;
  logic [`IVT_VEC_W-1:0] int_vec_reg;
  logic int_load;
  logic trap_block;
  logic held_live;
  logic better;
  logic int_take;

  // interrupt hold and withdraw conditions
  assign trap_block = (trp_state_reg != ivt_pkg::TRP_IDLE);
  assign held_live = src_if.pend[held_idx_reg] && (held_level_reg > i_cpu_level)
                     && !trap_block;
  assign better = pick_valid && (pick_level > held_level_reg);
  assign int_take = (arb_state_reg == ivt_pkg::ARB_REQ) && i_int_ack;
  assign int_load = (arb_state_reg == ivt_pkg::ARB_IDLE) && pick_valid && !trap_block;
  assign src_if.ack = int_take ? (N_SRC'(1) << held_idx_reg) : '0;

  // interrupt request sequencing
  always_comb begin
    arb_state_next = arb_state_reg;
    unique case (arb_state_reg)
      ivt_pkg::ARB_IDLE: begin
        if (int_load) begin
          arb_state_next = ivt_pkg::ARB_REQ;
        end
      end
      ivt_pkg::ARB_REQ: begin
        if (int_take || !held_live || better) begin
          arb_state_next = ivt_pkg::ARB_IDLE;
        end
      end
      default: begin
        arb_state_next = ivt_pkg::ARB_IDLE;
      end
    endcase
  end

  // interrupt state and held winner
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      arb_state_reg <= ivt_pkg::ARB_IDLE;
      held_idx_reg <= '0;
      held_level_reg <= '0;
    end else begin
      arb_state_reg <= arb_state_next;
      if (int_load) begin
        held_idx_reg <= pick_idx;
        held_level_reg <= pick_level;
      end
    end
  end

  // trap number and vector of the held winner
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      int_trap_reg <= '0;
      int_vec_reg <= '0;
    end else if (int_load) begin
      int_trap_reg <= src_trap(pick_idx);
      int_vec_reg <= trap_vec(src_trap(pick_idx));
    end
  end

  logic [N_TRAP-1:0] tpend_reg;
  logic [N_TRAP-1:0] tpend_next;
  logic [N_TRAP-1:0] taken_mask;
  logic [N_TRAP-1:0] class_b_mask;
  logic tp_valid;
  logic [TW-1:0] tp_idx;
  ivt_pkg::ivt_rank_type tp_rank;
  ivt_pkg::ivt_rank_type svc_rank_reg;
  ivt_pkg::ivt_rank_type saved_rank_reg;
  ivt_pkg::ivt_rank_type held_rank_reg;
  logic [TW-1:0] held_tidx_reg;
  logic [`IVT_TRAP_W-1:0] trap_num_reg;
  logic [`IVT_VEC_W-1:0] trap_vec_reg;
  logic trap_hit;
  logic trap_load;
  logic trap_take;
  logic trap_ret;

  // lowest pending or arriving index is the most urgent trap
  always_comb begin
    tp_valid = 1'b0;
    tp_idx = '0;
    for (int i = N_TRAP - 1; i >= 0; i--) begin
      if (tpend_reg[i] || i_trap_event[i]) begin
        tp_valid = 1'b1;
        tp_idx = TW'(i);
      end
    end
  end

  // trap entry decisions, never gated by enables or levels
  assign tp_rank = hw_rank(tp_idx);
  assign trap_hit = tp_valid && (tp_rank > svc_rank_reg);
  assign trap_take = (trp_state_reg == ivt_pkg::TRP_REQ) && i_trap_ack;
  assign trap_load = trap_hit && !trap_take && (trp_state_reg != ivt_pkg::TRP_SVC
                     || !i_trap_return);
  assign trap_ret = (trp_state_reg == ivt_pkg::TRP_SVC) && i_trap_return && !trap_hit;

  // shared-vector traps are all taken by one service
  for (genvar g = 0; g < N_TRAP; g++) begin : g_trap
    assign class_b_mask[g] = (TW'(g) >= `IVT_N_TRAP_A);
  end
  assign taken_mask = !trap_take ? '0 :
                      (held_rank_reg == `IVT_RANK_B) ? class_b_mask :
                      (N_TRAP'(1) << held_tidx_reg);
  assign tpend_next = i_trap_event | (tpend_reg & ~taken_mask);

  // trap service sequencing
  always_comb begin
    trp_state_next = trp_state_reg;
    unique case (trp_state_reg)
      ivt_pkg::TRP_IDLE: begin
        if (trap_load) begin
          trp_state_next = ivt_pkg::TRP_REQ;
        end
      end
      ivt_pkg::TRP_REQ: begin
        if (trap_take) begin
          trp_state_next = ivt_pkg::TRP_SVC;
        end
      end
      ivt_pkg::TRP_SVC: begin
        if (trap_load) begin
          trp_state_next = ivt_pkg::TRP_REQ;
        end else if (trap_ret && saved_rank_reg == `IVT_RANK_NONE) begin
          trp_state_next = ivt_pkg::TRP_IDLE;
        end
      end
      default: begin
        trp_state_next = ivt_pkg::TRP_IDLE;
      end
    endcase
  end

  // trap state, pending traps and nesting ranks
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      trp_state_reg <= ivt_pkg::TRP_IDLE;
      tpend_reg <= '0;
      svc_rank_reg <= `IVT_RANK_NONE;
      saved_rank_reg <= `IVT_RANK_NONE;
    end else begin
      trp_state_reg <= trp_state_next;
      tpend_reg <= tpend_next;
      if (trap_take) begin
        saved_rank_reg <= svc_rank_reg;
        svc_rank_reg <= held_rank_reg;
      end else if (trap_ret) begin
        svc_rank_reg <= saved_rank_reg;
        saved_rank_reg <= `IVT_RANK_NONE;
      end
    end
  end

  // held trap follows the most urgent pending one
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      held_rank_reg <= `IVT_RANK_NONE;
      held_tidx_reg <= '0;
      trap_num_reg <= '0;
      trap_vec_reg <= '0;
    end else if (trap_load) begin
      held_rank_reg <= tp_rank;
      held_tidx_reg <= tp_idx;
      trap_num_reg <= hw_trap(tp_idx);
      trap_vec_reg <= trap_vec(hw_trap(tp_idx));
    end
  end

  // outputs
  assign o_src_flag = src_if.flag;
  assign o_trap_flag = tfr_if.flag;
  assign tfr_if.ack = '0;
  assign o_int_req = (arb_state_reg == ivt_pkg::ARB_REQ);
  assign o_int_trap_num = int_trap_reg;
  assign o_int_vector = int_vec_reg;
  assign o_int_level = held_level_reg;
  assign o_trap_req = (trp_state_reg == ivt_pkg::TRP_REQ);
  assign o_trap_num = trap_num_reg;
  assign o_trap_vector = trap_vec_reg;
  assign o_trap_busy = trap_block;
endmodule

// ==== tb/ivt_top_chk.sv ====
// port assertions for the interrupt vector and trap map
`include "ivt_map.svh"
module ivt_top_chk #(
  parameter int N_SRC = `IVT_N_SRC,
  parameter int N_TRAP = `IVT_N_TRAP,
  parameter int PW = `IVT_PRIO_W
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [N_SRC-1:0] i_src_event,
  input wire logic [PW-1:0] i_cpu_level,
  input wire logic [N_SRC-1:0] o_src_flag,
  input wire logic o_int_req,
  input wire logic [`IVT_TRAP_W-1:0] o_int_trap_num,
  input wire logic [`IVT_VEC_W-1:0] o_int_vector,
  input wire logic [PW-1:0] o_int_level,
  input wire logic i_int_ack,
  input wire logic [N_TRAP-1:0] i_trap_event,
  input wire logic [N_TRAP-1:0] o_trap_flag,
  input wire logic o_trap_req,
  input wire logic [`IVT_TRAP_W-1:0] o_trap_num,
  input wire logic [`IVT_VEC_W-1:0] o_trap_vector,
  input wire logic o_trap_busy
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // vectors are byte offsets of four times the trap number
  property p_int_vec;
    o_int_req |-> o_int_vector == {o_int_trap_num, 2'h0};
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("int vector not trap times four");
  property p_trap_vec;
    o_trap_req |-> o_trap_vector == {o_trap_num, 2'h0};
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
  property p_trap_num;
    o_trap_req |-> o_trap_num inside {7'h02, 7'h04, 7'h06, 7'h0A};
  endproperty
  a_trap_num: assert property (p_trap_num) else $error("bad hardware trap number");
  // trap flags and immediate trap request
  property p_tfr_set;
    |i_trap_event |=> (o_trap_flag & $past(i_trap_event)) == $past(i_trap_event);
  endproperty
  a_tfr_set: assert property (p_tfr_set) else $error("trap flag bit not set");
  property p_trap_now;
    |i_trap_event && !o_trap_busy |=> o_trap_req && o_trap_busy;
  endproperty
  a_trap_now: assert property (p_trap_now) else $error("trap not requested at once");
  property p_no_int_in_trap;
    o_trap_busy && $past(o_trap_busy) |-> !o_int_req;
  endproperty
  a_no_int_in_trap: assert property (p_no_int_in_trap) else $error("int during trap");
  // level and flag behaviour of standard requests
  property p_lvl;
    o_int_req |-> o_int_level > $past(i_cpu_level);
  endproperty
  a_lvl: assert property (p_lvl) else $error("request level not above cpu level");
  property p_src_set;
    |i_src_event |=> (o_src_flag & $past(i_src_event)) == $past(i_src_event);
  endproperty
  a_src_set: assert property (p_src_set) else $error("request flag not set");
  property p_ack_drop;
    o_int_req && i_int_ack |=> !o_int_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
endmodule

// ==== tb/ivt_cpu_model.sv ====
// behavioural cpu core accepting interrupt and trap requests
module ivt_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_ack_en,
  input wire logic i_ret_go,
  input wire logic i_int_req,
  input wire logic i_trap_req,
  input wire logic i_trap_busy,
  output logic o_int_ack = 1'h0,
  output logic o_trap_ack = 1'h0,
  output logic o_trap_return = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // acks only while requested; return only inside a service
  always @(negedge i_clk_sys) begin
    o_int_ack <= i_int_req & i_ack_en;
    o_trap_ack <= i_trap_req;
    o_trap_return <= i_ret_go & i_trap_busy & ~i_trap_req;
  end
endmodule

// ==== tb/interrupt_vector_and_trap_map_tb.sv ====
// self-checking bench for the interrupt vector and trap map
`include "ivt_map.svh"
module interrupt_vector_and_trap_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = `IVT_N_SRC;
  localparam logic [N-1:0] M2 = (N'(1) << 3) | (N'(1) << 40);
  logic i_clk_sys = 1'h0;
  logic i_nrst = 1'h0;
  logic [N-1:0] i_src_event = '0, i_src_enable = '0, i_src_clr = '0, o_src_flag;
  logic [N*4-1:0] i_src_prio = '0;
  logic [3:0] i_cpu_level = 4'h0, o_int_level, la, lb;
  logic o_int_req, o_trap_req, o_trap_busy, i_int_ack, i_trap_ack, i_trap_return;
  logic [6:0] o_int_trap_num, o_trap_num;
  logic [8:0] o_int_vector, o_trap_vector, fm;
  logic [8:0] i_trap_event = '0, i_tfr_clr = '0, o_trap_flag;
  logic ack_en = 1'h1, ret_go = 1'h0;
  integer seed = 28;
  int n_errors = 0, tests_run = 0, ta, tb1, tb2;
  ivt_top i_ivt_top (.i_clk_sys, .i_nrst, .i_src_event, .i_src_enable, .i_src_clr,
    .i_src_prio, .i_cpu_level, .o_src_flag, .o_int_req, .o_int_trap_num, .o_int_vector,
    .o_int_level, .i_int_ack, .i_trap_event, .i_tfr_clr, .o_trap_flag, .o_trap_req,
    .o_trap_num, .o_trap_vector, .i_trap_ack, .i_trap_return, .o_trap_busy);
  ivt_cpu_model i_ivt_cpu_model (.i_clk_sys, .i_ack_en(ack_en), .i_ret_go(ret_go),
    .i_int_req(o_int_req), .i_trap_req(o_trap_req), .i_trap_busy(o_trap_busy),
    .o_int_ack(i_int_ack), .o_trap_ack(i_trap_ack), .o_trap_return(i_trap_return));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  // expected trap number of each source index
  function automatic logic [6:0] exp_trap(input int i);
    if (i < 10) return 7'h16 + 7'(i);
    if (i < 23) return 7'h30 + 7'(i - 10);
    if (i < 26) return 7'h44 + 7'(i - 23);
    if (i < 28) return 7'h20 + 7'(i - 26);
    if (i < 30) return 7'h3D + 7'(i - 28);
    if (i < 36) return 7'h22 + 7'(i - 30);
    if (i < 38) return 7'h28 + 7'(i - 36);
    if (i == 38) return 7'h2A;
    if (i == 39) return 7'h47;
    if (i < 42) return 7'h2B + 7'(i - 40);
    if (i < 45) return 7'h2D + 7'(i - 42);
    if (i == 45) return 7'h3F;
    return 7'h40 + 7'(i - 46);
  endfunction
  function automatic int rnd(input int n);
    return {$random(seed)} % n;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    #100us;
    n_errors++;
    test_done;
  end
  initial begin
    for (int i = 0; i < N; i++) i_src_prio[4*i+:4] = 4'(rnd(15) + 1);
    cyc(16);
    chk("trap_flag", 9'h000, o_trap_flag);
    i_nrst = 1'h1;
    cyc(1);
    // every source alone: trap number, vector, level, ack clears flag
    for (int i = 0; i < N; i++) begin
      i_src_enable = N'(1) << i;
      i_src_event = N'(1) << i;
      cyc(1);
      i_src_event = '0;
      chk("src_flag", 1'h1, o_src_flag[i]);
      cyc(1);
      chk("int_req", 1'h1, o_int_req);
      chk("int_trap_num", exp_trap(i), o_int_trap_num);
      chk("int_vector", {exp_trap(i), 2'h0}, o_int_vector);
      chk("int_level", i_src_prio[4*i+:4], o_int_level);
      cyc(1);
      chk("src_flag", 1'h0, o_src_flag[i]);
    end
    // flag without enable, cpu level masking, software clear
    ack_en = 1'h0;
    i_src_enable = '0;
    i_src_event[7] = 1'h1;
    cyc(1);
    i_src_event = '0;
    cyc(2);
    chk("int_req", 1'h0, o_int_req);
    chk("src_flag", 1'h1, o_src_flag[7]);
    i_src_enable[7] = 1'h1;
    cyc(1);
    chk("int_req", 1'h1, o_int_req);
    i_cpu_level = 4'hF;
    cyc(1);
    chk("int_req", 1'h0, o_int_req);
    i_cpu_level = 4'h0;
    cyc(1);
    chk("int_req", 1'h1, o_int_req);
    i_src_clr[7] = 1'h1;
    cyc(1);
    i_src_clr = '0;
    chk("src_flag", 1'h0, o_src_flag[7]);
    cyc(1);
    chk("int_req", 1'h0, o_int_req);
    // two sources at random levels, ties go to the lower index
    repeat (6) begin
      la = 4'(rnd(15) + 1);
      lb = 4'(rnd(15) + 1);
      i_src_prio[12+:4] = la;
      i_src_prio[160+:4] = lb;
      i_src_enable = M2;
      i_src_event = M2;
      cyc(1);
      i_src_event = '0;
      cyc(1);
      chk("int_trap_num", (lb > la) ? exp_trap(40) : exp_trap(3), o_int_trap_num);
      i_src_clr = M2;
      cyc(1);
      i_src_clr = '0;
      cyc(2);
    end
    // a higher level arriving withdraws the held request, then wins
    i_src_prio[12+:4] = 4'h1;
    i_src_prio[160+:4] = 4'hF;
    i_src_enable = M2;
    i_src_event = N'(1) << 3;
    cyc(2);
    i_src_event = N'(1) << 40;
    cyc(1);
    chk("int_trap_num", exp_trap(3), o_int_trap_num);
    i_src_event = '0;
    cyc(1);
    chk("int_req", 1'h0, o_int_req);
    cyc(1);
    chk("int_trap_num", exp_trap(40), o_int_trap_num);
    chk("int_level", 4'hF, o_int_level);
    i_src_clr = M2;
    cyc(1);
    i_src_clr = '0;
    cyc(2);
    // class B trap over a pending interrupt, class A nests, class B waits
    i_src_enable = N'(1);
    i_src_event = N'(1);
    cyc(1);
    i_src_event = '0;
    cyc(1);
    chk("int_req", 1'h1, o_int_req);
    tb1 = 3 + rnd(6);
    tb2 = 3 + rnd(6);
    ta = rnd(3);
    fm = (9'h001 << ta) | (9'h001 << tb1) | (9'h001 << tb2);
    i_trap_event[tb1] = 1'h1;
    cyc(1);
    i_trap_event = '0;
    chk("trap_req", 1'h1, o_trap_req);
    chk("trap_vector", 9'h028, o_trap_vector);
    chk("trap_flag", 9'h001 << tb1, o_trap_flag);
    cyc(1);
    chk("int_req", 1'h0, o_int_req);
    i_trap_event[ta] = 1'h1;
    cyc(1);
    i_trap_event = '0;
    chk("trap_req", 1'h1, o_trap_req);
    chk("trap_num", 7'(2 * ta + 2), o_trap_num);
    chk("trap_vector", 9'(8 * ta + 8), o_trap_vector);
    cyc(1);
    i_trap_event[tb2] = 1'h1;
    cyc(1);
    i_trap_event = '0;
    chk("trap_req", 1'h0, o_trap_req);
    chk("int_req", 1'h0, o_int_req);
    chk("trap_flag", fm, o_trap_flag);
    ret_go = 1'h1;
    cyc(30);
    ret_go = 1'h0;
    chk("trap_busy", 1'h0, o_trap_busy);
    chk("int_req", 1'h1, o_int_req);
    i_tfr_clr = '1;
    cyc(1);
    i_tfr_clr = '0;
    chk("trap_flag", 9'h000, o_trap_flag);
    test_done;
  end
endmodule
bind ivt_top ivt_top_chk #(.N_SRC(N_SRC), .N_TRAP(N_TRAP), .PW(PW)) i_ivt_top_chk (
  .i_clk_sys, .i_nrst, .i_src_event, .i_cpu_level, .o_src_flag, .o_int_req,
  .o_int_trap_num, .o_int_vector, .o_int_level, .i_int_ack, .i_trap_event,
  .o_trap_flag, .o_trap_req, .o_trap_num, .o_trap_vector, .o_trap_busy);
